// File: dqodt_ctrl.sv
/*
 dq on-die termination controller: decides termination state per link clock
 cycle from decoded write commands, mode register and power states.
 assumes the link clock, clock enable and command strobes come from the pins
 and are sampled by ref_clk_i, which must be well above twice the link rate.
*/
`timescale 1ns/100ps
module dqodt_ctrl
  import dqodt_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [3:0] avs_address_i,
  input  wire logic       avs_read_i,
  input  wire logic       avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]     avs_readdata_o,
  output logic            avs_waitrequest_o,
  input  wire logic       link_clk_i,
  input  wire logic       cke_i,
  input  wire logic       wr_first_i,
  input  wire logic       cas2_i,
  input  wire logic       trr_act_i,
  output logic            dq_term_on_o,
  output logic            dqs_term_on_o,
  output logic [2:0]      dq_term_code_o,
  output logic [2:0]      ca_term_code_o,
  output logic            trr_refresh_o
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] lclk_sync_reg;
  logic [1:0] cke_sync_reg;
  logic [1:0] wr_sync_reg;
  logic [1:0] cas_sync_reg;
  logic [1:0] act_sync_reg;
  logic       lclk_prev_reg;
  logic       lclk_rise;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lclk_sync_reg <= 2'h0;
      cke_sync_reg  <= 2'h0;
      wr_sync_reg   <= 2'h0;
      cas_sync_reg  <= 2'h0;
      act_sync_reg  <= 2'h0;
      lclk_prev_reg <= 1'b0;
    end else begin
      lclk_sync_reg <= {lclk_sync_reg[0], link_clk_i};
      cke_sync_reg  <= {cke_sync_reg[0], cke_i};
      wr_sync_reg   <= {wr_sync_reg[0], wr_first_i};
      cas_sync_reg  <= {cas_sync_reg[0], cas2_i};
      act_sync_reg  <= {act_sync_reg[0], trr_act_i};
      lclk_prev_reg <= lclk_sync_reg[1];
    end
  end
  assign lclk_rise = lclk_sync_reg[1] & ~lclk_prev_reg;

  // ==========================================================
  // registers
  logic [6:0] mode_reg;
  logic [4:0] ctrl_reg;
  logic       trr_en_reg;
  logic       rd_pend_reg;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~rd_pend_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg   <= MODE_RESET;
      ctrl_reg   <= CTRL_RESET;
      trr_en_reg <= 1'b0;
    end else if (avs_write_i && rd_pend_reg) begin
      unique case (avs_address_i)
        DQODT_MODE_OFS: mode_reg   <= avs_writedata_i[6:0];
        DQODT_CTRL_OFS: ctrl_reg   <= avs_writedata_i[4:0];
        DQODT_TRR_OFS:  trr_en_reg <= avs_writedata_i[0];
        default: ;
      endcase
    end
  end

  // one wait cycle for every access, then read data stands with waitrequest low
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= (avs_read_i | avs_write_i) & ~rd_pend_reg;
    end
  end

  logic [2:0] dq_field;
  logic       term_enabled;
  logic       term_active_reg;
  dqodt_state_t state_reg;

  assign dq_field     = mode_reg[DQ_FLD_LSB +: 3];
  assign term_enabled = (dq_field != CODE_OFF);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && !rd_pend_reg) begin
      unique case (avs_address_i)
        DQODT_MODE_OFS:   avs_readdata_o <= {25'h0, mode_reg};
        DQODT_CTRL_OFS:   avs_readdata_o <= {27'h0, ctrl_reg};
        DQODT_STATUS_OFS: avs_readdata_o <= {28'h0, state_reg, term_active_reg};
        DQODT_TRR_OFS:    avs_readdata_o <= {31'h0, trr_en_reg};
        default:          avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // latency sequencer, counts link clock edges
  logic [5:0] on_lat;
  logic [5:0] off_lat;
  logic [5:0] cnt_reg;
  logic       armed_reg;

  assign on_lat  = ctrl_reg[CTRL_SETB_BIT] ? ON_LAT_B : ON_LAT_A;
  assign off_lat = (ctrl_reg[CTRL_SETB_BIT] ? OFF_LAT_B : OFF_LAT_A)
                 + (ctrl_reg[CTRL_BL32_BIT] ? BL32_EXTRA : 6'h00);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_reg <= 1'b0;
      state_reg <= DQODT_IDLE;
      cnt_reg   <= 6'h00;
    end else if (lclk_rise) begin
      unique case (state_reg)
        DQODT_IDLE: begin
          if (wr_sync_reg[1] && term_enabled) begin
            armed_reg <= 1'b1;
          end
          if (armed_reg && cas_sync_reg[1]) begin
            armed_reg <= 1'b0;
            cnt_reg   <= 6'h01;
            state_reg <= DQODT_WAIT;
          end
        end
        DQODT_WAIT: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == on_lat) begin
            state_reg <= DQODT_ON;
          end
        end
        DQODT_ON: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == off_lat) begin
            state_reg <= DQODT_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // output decision
  logic pd_mode;
  logic sr_mode;
  logic wlvl_mode;
  logic dq_on_next;

  assign pd_mode   = ctrl_reg[CTRL_PD_BIT];
  assign sr_mode   = ctrl_reg[CTRL_SR_BIT];
  assign wlvl_mode = ctrl_reg[CTRL_WLVL_BIT];

  always_comb begin
    dq_on_next = term_enabled && (state_reg == DQODT_ON);
    if (sr_mode) begin
      dq_on_next = term_enabled && cke_sync_reg[1];
    end
    if (pd_mode || wlvl_mode) begin
      dq_on_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      term_active_reg <= 1'b0;
      dq_term_on_o    <= 1'b0;
      dqs_term_on_o   <= 1'b0;
      dq_term_code_o  <= CODE_OFF;
      ca_term_code_o  <= CODE_OFF;
      trr_refresh_o   <= 1'b0;
    end else begin
      term_active_reg <= dq_on_next;
      dq_term_on_o    <= dq_on_next;
      dqs_term_on_o   <= wlvl_mode ? (term_enabled && !pd_mode) : dq_on_next;
      dq_term_code_o  <= dq_field;
      ca_term_code_o  <= mode_reg[CA_FLD_LSB +: 3];
      trr_refresh_o   <= trr_en_reg && act_sync_reg[1];
    end
  end

  // ==========================================================
  // checks
  property p_pd_off;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      pd_mode |=> !dq_term_on_o;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("termination on in power-down");

  property p_zero_off;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      !term_enabled |=> !dq_term_on_o;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("termination on with field zero");

  property p_wlvl_dq;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      wlvl_mode |=> !dq_term_on_o;
  endproperty
  a_wlvl_dq: assert property (p_wlvl_dq) else $error("dq terminated in leveling");

  property p_wlvl_dqs;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (wlvl_mode && term_enabled && !pd_mode) |=> dqs_term_on_o;
  endproperty
  a_wlvl_dqs: assert property (p_wlvl_dqs) else $error("dqs not terminated");

  property p_code;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      1'b1 |=> dq_term_code_o == $past(dq_field);
  endproperty
  a_code: assert property (p_code) else $error("code mismatch");

  property p_sr;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (sr_mode && !pd_mode && !wlvl_mode && !cke_sync_reg[1]) |=> !dq_term_on_o;
  endproperty
  a_sr: assert property (p_sr) else $error("on in self refresh with cke low");

  property p_idle;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (state_reg != DQODT_ON && !sr_mode) |=> !dq_term_on_o;
  endproperty
  a_idle: assert property (p_idle) else $error("on without write");

  property p_onset;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (lclk_rise && state_reg == DQODT_WAIT && cnt_reg == on_lat) |=> state_reg == DQODT_ON;
  endproperty
  a_onset: assert property (p_onset) else $error("turn-on latency missed");

  property p_offset;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (lclk_rise && state_reg == DQODT_ON && cnt_reg == off_lat) |=> state_reg == DQODT_IDLE;
  endproperty
  a_offset: assert property (p_offset) else $error("turn-off latency missed");

  property p_dqs_zero;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (wlvl_mode && !term_enabled) |=> !dqs_term_on_o;
  endproperty
  a_dqs_zero: assert property (p_dqs_zero) else $error("dqs on with field zero");

  property p_dqs_pd;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      pd_mode |=> !dqs_term_on_o;
  endproperty
  a_dqs_pd: assert property (p_dqs_pd) else $error("dqs on in power-down");

  property p_sr_on;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (sr_mode && !pd_mode && !wlvl_mode && term_enabled && cke_sync_reg[1]) |=> dq_term_on_o;
  endproperty
  a_sr_on: assert property (p_sr_on) else $error("off in self refresh, cke high");

  property p_ca_code;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      1'b1 |=> ca_term_code_o == $past(mode_reg[CA_FLD_LSB +: 3]);
  endproperty
  a_ca_code: assert property (p_ca_code) else $error("ca code mismatch");

  property p_trr;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (trr_en_reg && act_sync_reg[1]) |=> trr_refresh_o;
  endproperty
  a_trr: assert property (p_trr) else $error("adjacent refresh missed");

  property p_no_arm;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (lclk_rise && state_reg == DQODT_IDLE && !armed_reg && !term_enabled) |=> !armed_reg;
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("armed with field zero");

  property p_start;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (state_reg == DQODT_IDLE && !armed_reg) |=> state_reg == DQODT_IDLE;
  endproperty
  a_start: assert property (p_start) else $error("sequence started without write");

  property p_wait;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (state_reg == DQODT_WAIT) |=> state_reg != DQODT_IDLE;
  endproperty
  a_wait: assert property (p_wait) else $error("turn-on wait abandoned");

  property p_on_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (state_reg == DQODT_ON && !lclk_rise) |=> state_reg == DQODT_ON;
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("on state left off a link edge");
endmodule : dqodt_ctrl

// File: dqodt_pkg.sv
/*
 package for the dq on-die termination control block: mode register fields,
 latency table values, avalon register map.
 assumes a single 100 MHz core clock and an avalon-mm master on the host side.
*/
package dqodt_pkg;
  // avalon register byte offsets
  localparam logic [3:0] DQODT_MODE_OFS   = 4'h0;
  localparam logic [3:0] DQODT_CTRL_OFS   = 4'h4;
  localparam logic [3:0] DQODT_STATUS_OFS = 4'h8;
  localparam logic [3:0] DQODT_TRR_OFS    = 4'hc;
  // termination mode register fields
  localparam int DQ_FLD_LSB = 0;
  localparam int CA_FLD_LSB = 4;
  localparam logic [6:0] MODE_RESET = 7'h00;
  // control register bits
  localparam int CTRL_SETB_BIT = 0;
  localparam int CTRL_BL32_BIT = 1;
  localparam int CTRL_WLVL_BIT = 2;
  localparam int CTRL_PD_BIT   = 3;
  localparam int CTRL_SR_BIT   = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // resistance codes
  localparam logic [2:0] CODE_OFF = 3'h0;
  localparam logic [2:0] CODE_240 = 3'h1;
  localparam logic [2:0] CODE_40  = 3'h6;
  // latencies in link clock cycles for the top speed bin
  localparam logic [5:0] ON_LAT_A   = 6'h08;
  localparam logic [5:0] ON_LAT_B   = 6'h18;
  localparam logic [5:0] OFF_LAT_A  = 6'h1c;
  localparam logic [5:0] OFF_LAT_B  = 6'h2c;
  localparam logic [5:0] BL32_EXTRA = 6'h08;
  typedef enum logic [2:0] {
    DQODT_IDLE = 3'b001,
    DQODT_WAIT = 3'b010,
    DQODT_ON   = 3'b100
  } dqodt_state_t;
endpackage : dqodt_pkg

// File: dqodt_host_model.sv
/*
 controller-side model: link clock, write command pair, target activate.
 assumes the controller runs the link clock continuously at the top bin.
*/
`timescale 1ns/100ps
module dqodt_host_model (
  output logic link_clk_o,
  output logic wr_first_o,
  output logic cas2_o,
  output logic trr_act_o
);
  // ==========
  // link clock, top speed bin only
  initial begin
    link_clk_o = 1'b0;
    wr_first_o = 1'b0;
    cas2_o     = 1'b0;
    trr_act_o  = 1'b0;
    #3;
    forever #40 link_clk_o = ~link_clk_o;
  end

  task automatic write_cmd();
    @(negedge link_clk_o);
    wr_first_o = 1'b1;
    @(negedge link_clk_o);
    wr_first_o = 1'b0;
    cas2_o     = 1'b1;
    @(negedge link_clk_o);
    cas2_o = 1'b0;
  endtask : write_cmd

  // activate limit reached: hand the row to targeted refresh
  task automatic target_act();
    @(negedge link_clk_o);
    trr_act_o = 1'b1;
    @(negedge link_clk_o);
    trr_act_o = 1'b0;
  endtask : target_act
endmodule : dqodt_host_model

// File: dqodt_ctrl_bench.sv
/*
 self-checking bench for the dq termination controller.
 assumes the host model above drives the link side.
*/
`timescale 1ns/100ps
module dqodt_ctrl_bench;
  import dqodt_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i, avs_read_i, avs_write_i, cke_i;
  logic [3:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic        avs_waitrequest_o, link_clk_i, wr_first_i, cas2_i, trr_act_i;
  logic        dq_term_on_o, dqs_term_on_o, trr_refresh_o;
  logic [2:0]  dq_term_code_o, ca_term_code_o;
  int          bad_count = 0;
  int          cmp_count = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  dqodt_ctrl u_dqodt_ctrl (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .link_clk_i(link_clk_i), .cke_i(cke_i),
    .wr_first_i(wr_first_i), .cas2_i(cas2_i), .trr_act_i(trr_act_i),
    .dq_term_on_o(dq_term_on_o), .dqs_term_on_o(dqs_term_on_o),
    .dq_term_code_o(dq_term_code_o), .ca_term_code_o(ca_term_code_o),
    .trr_refresh_o(trr_refresh_o));
  dqodt_host_model u_dqodt_host_model (.link_clk_o(link_clk_i), .wr_first_o(wr_first_i),
    .cas2_o(cas2_i), .trr_act_o(trr_act_i));

  // ==========
  // shared tasks
  task automatic summarize();
    $display("checks %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_read_i      <= !w;
    avs_write_i     <= w;
    avs_writedata_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (n == 20) begin
      bad_count++;
      summarize();
    end
  endtask : bus

  task automatic settle();
    repeat (12) @(posedge ref_clk_i);
  endtask : settle

  // first link edge, counted from the cas2 edge, that shows on and then off
  task automatic lat_case(input logic [31:0] ctl, input int e_on, input int e_off);
    int j;
    int on_j;
    int off_j;
    on_j  = 0;
    off_j = 0;
    bus(1'b1, DQODT_CTRL_OFS, ctl);
    fork
      u_dqodt_host_model.write_cmd();
    join_none
    for (j = 0; j < 40; j++) begin
      @(posedge link_clk_i);
      if (cas2_i === 1'b1) break;
    end
    if (j == 40) begin
      bad_count++;
      summarize();
    end
    for (j = 1; j < 70; j++) begin
      @(posedge link_clk_i);
      if (dq_term_on_o === 1'b1 && on_j == 0) on_j = j;
      if (on_j != 0 && off_j == 0 && dq_term_on_o === 1'b0) off_j = j;
    end
    chk(32'(on_j), 32'(e_on));
    chk(32'(off_j), 32'(e_off));
  endtask : lat_case

  // ==========
  // scenarios
  task automatic t_reset();
    chk({dq_term_on_o, dqs_term_on_o, trr_refresh_o}, 32'h0);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, DQODT_MODE_OFS, 32'h0);
    chk(rd, 32'(MODE_RESET));
    bus(1'b0, DQODT_CTRL_OFS, 32'h0);
    chk(rd, 32'(CTRL_RESET));
    bus(1'b0, DQODT_STATUS_OFS, 32'h0);
    chk(rd, {28'h0, DQODT_IDLE, 1'b0});
  endtask : t_reset

  task automatic t_codes();
    for (int c = 1; c < 7; c++) begin
      bus(1'b1, DQODT_MODE_OFS, 32'((c << CA_FLD_LSB) | (7 - c)));
      settle();
      chk(32'(dq_term_code_o), 32'(7 - c));
      chk(32'(ca_term_code_o), 32'(c));
      chk(32'(dq_term_on_o), 32'h0);
      bus(1'b0, DQODT_MODE_OFS, 32'h0);
      chk(rd, 32'((c << CA_FLD_LSB) | (7 - c)));
    end
  endtask : t_codes

  task automatic t_lat();
    bus(1'b1, DQODT_MODE_OFS, 32'(CODE_240));
    lat_case(32'h0, ON_LAT_A + 1, OFF_LAT_A + 1);
    lat_case(32'h1 << CTRL_SETB_BIT, ON_LAT_B + 1, OFF_LAT_B + 1);
    lat_case(32'h1 << CTRL_BL32_BIT, ON_LAT_A + 1, OFF_LAT_A + BL32_EXTRA + 1);
    lat_case(32'h1 << CTRL_PD_BIT, 0, 0);
    bus(1'b1, DQODT_MODE_OFS, 32'(CODE_OFF));
    lat_case(32'h0, 0, 0);
  endtask : t_lat

  task automatic t_power();
    bus(1'b1, DQODT_MODE_OFS, 32'(CODE_40));
    bus(1'b1, DQODT_CTRL_OFS, 32'h1 << CTRL_SR_BIT);
    cke_i <= 1'b0;
    settle();
    chk(32'(dq_term_on_o), 32'h0);
    cke_i <= 1'b1;
    settle();
    chk(32'(dq_term_on_o), 32'h1);
    bus(1'b1, DQODT_CTRL_OFS, 32'h1 << CTRL_WLVL_BIT);
    settle();
    chk({dqs_term_on_o, dq_term_on_o}, 32'h2);
    lat_case(32'h1 << CTRL_WLVL_BIT, 0, 0);
    bus(1'b1, DQODT_MODE_OFS, 32'(CODE_OFF));
    settle();
    chk({dqs_term_on_o, dq_term_on_o}, 32'h0);
  endtask : t_power

  task automatic t_trr();
    logic seen;
    seen = 1'b0;
    bus(1'b1, DQODT_TRR_OFS, 32'h1);
    fork
      u_dqodt_host_model.target_act();
    join_none
    for (int n = 0; n < 40 && seen !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      seen = trr_refresh_o;
    end
    chk(32'(seen), 32'h1);
    if (seen !== 1'b1) summarize();
  endtask : t_trr

  initial begin
    resetn_i        = 1'b0;
    avs_address_i   = 4'h0;
    avs_read_i      = 1'b0;
    avs_write_i     = 1'b0;
    avs_writedata_i = 32'h0;
    cke_i           = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_codes();
    t_lat();
    t_power();
    t_trr();
    summarize();
  end
endmodule : dqodt_ctrl_bench
